// ==== micro_bus_model.sv ====
module micro_bus_model
(
	input  wire logic                        clk,
	output tuner_regs_pkg::ctl_bus_type      bus,
	input  wire logic [7:0]                  rd_data,
	input  wire logic                        rd_oe_n
);
	timeunit 1ns;
	timeprecision 1ns;
	import tuner_regs_pkg::*;

	// ----------------------------------------
	// Control bus cycles
	// ----------------------------------------
	initial bus = '0;

	task automatic write_word(input logic [7:0] dest, input logic [31:0] value);
		for (int i = 0; i <= 4; i++)
		begin
			@(negedge clk);
			bus.wr <= 1'b1;
			bus.addr <= 3'(i);
			bus.data <= (i == 4) ? dest : value[8*i +: 8];
		end
		@(negedge clk);
		bus.wr <= 1'b0;
		bus.data <= ~bus.data;
	endtask

	// Reads the four snapshot bytes, notes whether the drive stayed on
	task automatic read_word(output logic [31:0] value, output logic oe_ok);
		oe_ok = 1'b1;
		for (int i = 0; i <= 4; i++)
		begin
			@(negedge clk);
			if (i > 0)
			begin
				value[8*(i-1) +: 8] = rd_data;
				oe_ok = oe_ok & ~rd_oe_n;
			end
			bus.rd <= (i < 4);
			bus.addr <= 3'(i);
		end
	endtask
endmodule

// ==== sample_hold.sv ====
module sample_hold
#(
	parameter int ACC_W = 32
)
(
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             capture,
	input  wire logic [ACC_W-1:0] acc_in,
	input  wire logic [1:0]       byte_sel,
	output logic      [7:0]       byte_out
);
	import tuner_regs_pkg::*;

	logic [ACC_W-1:0] held_reg;

	// ----------------------------------------------------------------
	// Snapshot of the loop-filter accumulator
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
			held_reg <= '0;
		else if (capture)
			held_reg <= acc_in;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			byte_out <= 8'h00;
		else
			byte_out <= held_reg[{byte_sel, 3'b000} +: 8];
	end

	capture_value_a: assert property (@(posedge clk) disable iff (srst)
		capture |=> held_reg == $past(acc_in))
		else $error("accumulator snapshot not taken");

	hold_value_a: assert property (@(posedge clk) disable iff (srst)
		!capture |=> $stable(held_reg))
		else $error("snapshot changed without a capture");

endmodule

// ==== tuner_ctl_regs.sv ====
// Overview of operation
// - Phase offset adds pi times n/128
// - Test mode forces sample phase pins
// - Test mode forces sample strobe pin
// - Test mode forces level detector pin
// - Test mode forces in-phase pins
// - Test mode forces output valid pin
// - Test mode forces LO phase marker
// - Test mode forces quadrature pins
// - Test enable is format register bit 3
// - Enable low means normal outputs
// - Write to 9 captures gain accumulator
// - Phase at 7, test at 8
module tuner_ctl_regs
#(
	parameter int ACC_W = 32
)
(
	input  wire logic                         clk,
	input  wire logic                         srst,
	input  wire tuner_regs_pkg::ctl_bus_type  ctl_bus,
	output logic      [7:0]                   control_data_lines_out,
	output logic                              control_data_lines_oe_n,
	input  wire logic [31:0]                  nco_phase,
	output logic      [31:0]                  offset_phase,
	input  wire logic [ACC_W-1:0]             gain_accumulator,
	input  wire tuner_regs_pkg::out_pins_type normal_pins,
	output tuner_regs_pkg::out_pins_type      pins,
	output logic      [tuner_regs_pkg::IO_FORMAT_W-1:0] io_format
);
	import tuner_regs_pkg::*;

	logic [STAGE_BYTES-1:0][7:0] stage_reg;
	logic [PHASE_W-1:0]          phase_reg;
	logic [TEST_W-1:0]           test_reg;
	logic                        xfer;
	logic                        test_en;
	logic                        gain_accumulator_sample;
	logic [31:0]                 stage_word;
	logic [31:0]                 phase_add;

	assign stage_word = stage_reg;
	assign xfer       = ctl_bus.wr && (ctl_bus.addr == ADDR_XFER);
	assign test_en    = io_format[TEST_ENABLE_BIT];
	assign gain_accumulator_sample = xfer && (ctl_bus.data == DEST_GAIN_SAMPLE);
	assign phase_add  = {phase_reg, {PHASE_SHIFT{1'b0}}};

	// ----------------------------------------------------------------
	// Staging bytes, one per low bus address
	// ----------------------------------------------------------------
	generate
		for (genvar i = 0; i < STAGE_BYTES; i++)
		begin : g_stage
			always_ff @(posedge clk)
			begin
				if (srst)
					stage_reg[i] <= STAGE_RESET[i*8 +: 8];
				else if (ctl_bus.wr && ctl_bus.addr == 3'(i))
					stage_reg[i] <= ctl_bus.data;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Destination registers, loaded from the staging word
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
			io_format <= IO_FORMAT_RESET;
		else if (xfer && ctl_bus.data == DEST_IO_FORMAT)
			io_format <= stage_word[IO_FORMAT_W-1:0];
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			phase_reg <= PHASE_RESET;
		else if (xfer && ctl_bus.data == DEST_PHASE_OFFSET)
			phase_reg <= stage_word[PHASE_W-1:0];
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			test_reg <= TEST_RESET;
		else if (xfer && ctl_bus.data == DEST_TEST)
			test_reg <= stage_word[TEST_W-1:0];
	end

	// ----------------------------------------------------------------
	// Carrier phase with offset applied
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
			offset_phase <= 32'h00000000;
		else
			offset_phase <= nco_phase + phase_add;
	end

	// ----------------------------------------------------------------
	// Output pins, forced from the test register in test mode
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
			pins <= '0;
		else if (test_en)
			pins <= out_pins_type'(test_reg);
		else
			pins <= normal_pins;
	end

	// ----------------------------------------------------------------
	// Snapshot readback on the control data lines
	// ----------------------------------------------------------------
	sample_hold #(
		.ACC_W    (ACC_W)
	) u_hold (
		.clk      (clk),
		.srst     (srst),
		.capture  (gain_accumulator_sample),
		.acc_in   (gain_accumulator),
		.byte_sel (ctl_bus.addr[1:0]),
		.byte_out (control_data_lines_out)
	);

	always_ff @(posedge clk)
	begin
		if (srst)
			control_data_lines_oe_n <= 1'b1;
		else
			control_data_lines_oe_n <= ~ctl_bus.rd;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	phase_apply_a: assert property (
		!$past(srst) |-> offset_phase == $past(nco_phase) + {$past(phase_reg), 24'h000000})
		else $error("phase offset not applied");

	force_phase_a: assert property (
		$past(test_en) |-> pins.sample_phase == $past(test_reg[4:0]))
		else $error("sample phase not forced");

	force_strobe_a: assert property (
		$past(test_en) |-> pins.sample_strobe == $past(test_reg[5]))
		else $error("sample strobe not forced");

	force_level_a: assert property (
		$past(test_en) |-> pins.level_detect == $past(test_reg[6]))
		else $error("level detect not forced");

	force_inphase_a: assert property (
		$past(test_en) |-> pins.inphase == $past(test_reg[16:7]))
		else $error("in-phase not forced");

	force_valid_a: assert property (
		$past(test_en) |-> pins.output_valid == $past(test_reg[17]))
		else $error("output valid not forced");

	force_marker_a: assert property (
		$past(test_en) |-> pins.lo_phase_marker == $past(test_reg[18]))
		else $error("lo marker not forced");

	force_quad_a: assert property (
		$past(test_en) |-> pins.quadrature == $past(test_reg[28:19]))
		else $error("quadrature not forced");

	enable_source_a: assert property (
		xfer && ctl_bus.data == 8'h04 |=> test_en == $past(stage_reg[0][3]))
		else $error("test enable not from format bit 3");

	normal_follow_a: assert property (
		!test_en ##1 !$past(test_en) |-> pins == $past(normal_pins))
		else $error("outputs not normal with test off");

	phase_load_a: assert property (
		xfer && ctl_bus.data == 8'h07 |=> phase_reg == $past(stage_reg[0]))
		else $error("phase register not loaded at 7");

	test_load_a: assert property (
		xfer && ctl_bus.data == 8'h08 |=> test_reg == $past(stage_word[28:0]))
		else $error("test register load wrong");

	read_drive_a: assert property (
		ctl_bus.rd |=> !control_data_lines_oe_n)
		else $error("data lines not driven on read");

	oe_release_a: assert property (
		!ctl_bus.rd |=> control_data_lines_oe_n)
		else $error("data lines driven without a read");

	format_hold_a: assert property (
		!(xfer && ctl_bus.data == DEST_IO_FORMAT) |=> $stable(io_format))
		else $error("format register changed without a transfer");

	phase_hold_a: assert property (
		!(xfer && ctl_bus.data == DEST_PHASE_OFFSET) |=> $stable(phase_reg))
		else $error("phase register changed without a transfer");

	test_hold_a: assert property (
		!(xfer && ctl_bus.data == DEST_TEST) |=> $stable(test_reg))
		else $error("test register changed without a transfer");

	stage_write_a: assert property (
		ctl_bus.wr && ctl_bus.addr == 3'h3 |=> stage_reg[3] == $past(ctl_bus.data))
		else $error("staging byte not written");

	// ----------------------------------------------------------------
	// Cover points
	// ----------------------------------------------------------------
	test_mode_c: cover property (test_en ##1 test_en);
	capture_c:   cover property (gain_accumulator_sample ##2 ctl_bus.rd ##1 ctl_bus.rd);
	phase_set_c: cover property (xfer && ctl_bus.data == 8'h07);
	test_off_c:  cover property (test_en ##1 !test_en);
	bad_dest_c:  cover property (xfer && ctl_bus.data == 8'h0a);

endmodule

// ==== tuner_ctl_regs_test.sv ====
module tuner_ctl_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	import tuner_regs_pkg::*;

	logic                   clk;
	logic                   srst;
	ctl_bus_type            ctl_bus;
	logic [7:0]             rd_data;
	logic                   rd_oe_n;
	logic [31:0]            nco_phase;
	logic [31:0]            offset_phase;
	logic [31:0]            gain_acc;
	logic [31:0]            word;
	out_pins_type           normal_pins;
	out_pins_type           pins;
	logic [IO_FORMAT_W-1:0] io_format;
	logic                   oe_ok;
	logic [7:0]             offs [4] = '{8'h80, 8'h7f, 8'h01, 8'hff};
	int                     fail_count = 0;
	int                     samples_checked = 0;
	int                     cycles = 0;

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	tuner_ctl_regs #(.ACC_W(32)) u_dut
	(
		.clk                     (clk),
		.srst                    (srst),
		.ctl_bus                 (ctl_bus),
		.control_data_lines_out  (rd_data),
		.control_data_lines_oe_n (rd_oe_n),
		.nco_phase               (nco_phase),
		.offset_phase            (offset_phase),
		.gain_accumulator        (gain_acc),
		.normal_pins             (normal_pins),
		.pins                    (pins),
		.io_format               (io_format)
	);

	micro_bus_model u_micro
	(
		.clk     (clk),
		.bus     (ctl_bus),
		.rd_data (rd_data),
		.rd_oe_n (rd_oe_n)
	);

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic settle();
		repeat (3) @(negedge clk);
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fail_count++;
			test_done();
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		srst = 1'b1;
		nco_phase = 32'h12345678;
		gain_acc = 32'h89abcdef;
		normal_pins = 29'h0f0f0f0f;
		repeat (3) @(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		check("oe_n", {31'h0, rd_oe_n}, 32'h1);
		check("io_format", {21'h0, io_format}, 32'h0);
		check("pins", {3'h0, pins}, {3'h0, normal_pins});
		check("offset", offset_phase, nco_phase);
		foreach (offs[i])
		begin
			u_micro.write_word(DEST_PHASE_OFFSET, {24'ha5a5a5, offs[i]});
			settle();
			check("offset", offset_phase, nco_phase + {offs[i], 24'h0});
		end
		u_micro.write_word(DEST_TEST, 32'hfaaaaaaa);
		settle();
		check("pins", {3'h0, pins}, {3'h0, normal_pins});
		u_micro.write_word(DEST_IO_FORMAT, 32'hfffff808);
		settle();
		check("io_format", {21'h0, io_format}, 32'h00000008);
		check("pins", {3'h0, pins}, 32'h1aaaaaaa);
		u_micro.write_word(DEST_TEST, 32'h05555555);
		u_micro.write_word(8'h0a, 32'h00000000);
		settle();
		check("pins", {3'h0, pins}, 32'h05555555);
		u_micro.write_word(DEST_IO_FORMAT, 32'hfffff7f7);
		settle();
		check("pins", {3'h0, pins}, {3'h0, normal_pins});
		u_micro.write_word(DEST_GAIN_SAMPLE, 32'h00000000);
		gain_acc = 32'h0badf00d;
		u_micro.read_word(word, oe_ok);
		check("snapshot", word, 32'h89abcdef);
		check("read_oe", {31'h0, oe_ok}, 32'h1);
		@(negedge clk);
		check("oe_n", {31'h0, rd_oe_n}, 32'h1);
		test_done();
	end
endmodule

// ==== tuner_regs_pkg.sv ====
package tuner_regs_pkg;

	// ----------------------------------------------------------------
	// Control bus decode
	// ----------------------------------------------------------------
	localparam int          STAGE_BYTES       = 4;
	localparam logic [2:0]  ADDR_XFER         = 3'h4;
	localparam logic [7:0]  DEST_IO_FORMAT    = 8'h04;
	localparam logic [7:0]  DEST_PHASE_OFFSET = 8'h07;
	localparam logic [7:0]  DEST_TEST         = 8'h08;
	localparam logic [7:0]  DEST_GAIN_SAMPLE  = 8'h09;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int          IO_FORMAT_W       = 11;
	localparam int          TEST_ENABLE_BIT   = 3;
	localparam int          PHASE_W           = 8;
	localparam int          PHASE_SHIFT       = 24;
	localparam int          TEST_W            = 29;
	localparam logic [10:0] IO_FORMAT_RESET   = 11'h000;
	localparam logic [7:0]  PHASE_RESET       = 8'h00;
	localparam logic [28:0] TEST_RESET        = 29'h00000000;
	localparam logic [31:0] STAGE_RESET       = 32'h00000000;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [9:0] quadrature;
		logic       lo_phase_marker;
		logic       output_valid;
		logic [9:0] inphase;
		logic       level_detect;
		logic       sample_strobe;
		logic [4:0] sample_phase;
	} out_pins_type;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [2:0] addr;
		logic [7:0] data;
	} ctl_bus_type;

endpackage
